// *** pkg/cfcsb_pkg.sv ***
package cfcsb_pkg;

    // register byte offsets
    localparam logic [7:0]  cmd_off       = 8'h00;
    localparam logic [7:0]  operand_off   = 8'h04;
    localparam logic [7:0]  target_off    = 8'h08;
    localparam logic [7:0]  pc_off        = 8'h0C;
    localparam logic [7:0]  flags_off     = 8'h10;
    localparam logic [7:0]  status_off    = 8'h14;

    // command word fields
    localparam int          op_lsb        = 0;
    localparam int          op_w          = 5;
    localparam int          bitsel_lsb    = 8;
    localparam int          flagsel_lsb   = 12;
    localparam int          two_word_bit  = 16;

    // operand word fields
    localparam int          dst_lsb       = 0;
    localparam int          src_lsb       = 8;
    localparam int          imm_lsb       = 16;
    localparam int          io_lsb        = 24;

    // target word fields
    localparam int          addr_lsb      = 0;
    localparam int          disp_lsb      = 16;
    localparam int          disp_w        = 7;

    // status word fields
    localparam int          busy_bit      = 0;
    localparam int          skipped_bit   = 1;
    localparam int          taken_bit     = 2;
    localparam int          cycles_lsb    = 4;

    // status flag positions
    localparam int          flag_c        = 0;
    localparam int          flag_z        = 1;
    localparam int          flag_n        = 2;
    localparam int          flag_v        = 3;
    localparam int          flag_h        = 5;
    localparam int          flag_i        = 7;

    // reset values
    localparam logic [15:0] pc_reset      = 16'h0000;
    localparam logic [7:0]  flags_reset   = 8'h00;
    localparam logic [31:0] word_reset    = 32'h0000_0000;

    // cycle counts per outcome
    localparam logic [2:0]  cyc_direct    = 3'h4;
    localparam logic [2:0]  cyc_indirect  = 3'h3;
    localparam logic [2:0]  cyc_exit      = 3'h4;
    localparam logic [2:0]  cyc_single    = 3'h1;
    localparam logic [2:0]  cyc_skip_one  = 3'h2;
    localparam logic [2:0]  cyc_skip_two  = 3'h3;
    localparam logic [2:0]  cyc_taken     = 3'h2;

    // program counter steps
    localparam logic [15:0] step_next     = 16'h0001;
    localparam logic [15:0] step_skip_one = 16'h0002;
    localparam logic [15:0] step_skip_two = 16'h0003;

    // instruction codes, in command field order
    typedef enum logic [4:0] {
        op_direct_invoke,
        op_indirect_subroutine_invoke,
        op_subroutine_exit,
        op_interrupt_exit,
        op_compare_skip_equal,
        op_compare_regs,
        op_compare_with_borrow,
        op_compare_immediate,
        op_skip_reg_bit_clear,
        op_skip_reg_bit_set,
        op_skip_io_bit_clear,
        op_skip_io_bit_set,
        op_branch_flag_set,
        op_branch_flag_clear,
        op_branch_equal,
        op_branch_not_equal,
        op_branch_carry_set,
        op_branch_carry_clear
    } cfcsb_op_type;

    localparam logic [4:0]  op_count      = 5'h12;

    // execution sequencer states
    typedef enum logic {
        st_idle,
        st_run
    } cfcsb_state_type;

endpackage

// *** verilog/cfcsb_compare_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
module cfcsb_compare_unit
(
    // operands
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    input  wire logic       borrow_in,
    // flag results, the difference itself is never exposed
    output logic            flag_half,
    output logic            flag_over,
    output logic            flag_neg,
    output logic            flag_zero,
    output logic            flag_carry
);
    logic [8:0] diff;  // ninth bit is the borrow out

    // subtract with optional borrow
    assign diff       = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    // borrow out of bit 3
    assign flag_half  = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3]) | (diff[3] & ~minuend[3]);
    // signed overflow of the subtraction
    assign flag_over  = (minuend[7] & ~subtrahend[7] & ~diff[7]) | (~minuend[7] & subtrahend[7] & diff[7]);
    assign flag_neg   = diff[7];
    assign flag_zero  = (diff[7:0] == 8'h00);
    assign flag_carry = diff[8];
endmodule
`default_nettype wire

// *** verilog/cfcsb_cycle_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module cfcsb_cycle_timer
#(
    parameter int W = 3
)
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // state
    output logic              busy,
    output logic              last
);
    logic [W-1:0] remaining;  // cycles still to run

    // busy while cycles remain, last on the final cycle of the instruction
    assign busy = (remaining != '0);
    assign last = (remaining == W'(1));

    // down counter, frozen with the clock enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            remaining <= '0;
        else if (ce)
        begin
            if (load)
                remaining <= count;
            else if (busy)
                remaining <= remaining - W'(1);
        end
    end
endmodule
`default_nettype wire

// *** verilog/cfcsb_flow_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
module cfcsb_flow_unit
(
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // execution state
    output logic             exec_busy
);
    // register file
    logic [31:0] cmd;            // last accepted command
    logic [31:0] operand;        // register and immediate values
    logic [31:0] target;         // absolute, pointer or stacked word, displacement
    logic [15:0] pc;             // program counter
    logic [7:0]  status_flags;   // core status flags
    logic        skipped;        // last instruction skipped its successor
    logic        taken;          // last branch was taken
    logic [2:0]  last_cycles;    // cycles of last instruction

    // pending results, committed when the timer ends
    logic [15:0] pend_pc;
    logic [7:0]  pend_flags;
    cfcsb_pkg::cfcsb_state_type state;

    // apb helpers
    wire         setup_done = psel & penable & ~pready;
    wire         commit     = psel & penable & pready & ~pslverr;
    wire         hit_cmd    = (paddr == cfcsb_pkg::cmd_off);
    wire         hit_oper   = (paddr == cfcsb_pkg::operand_off);
    wire         hit_tgt    = (paddr == cfcsb_pkg::target_off);
    wire         hit_pc     = (paddr == cfcsb_pkg::pc_off);
    wire         hit_flags  = (paddr == cfcsb_pkg::flags_off);
    wire         hit_stat   = (paddr == cfcsb_pkg::status_off);
    wire         hit_any    = hit_cmd | hit_oper | hit_tgt | hit_pc | hit_flags | hit_stat;

    // command field extraction from the write data
    wire [4:0]   new_op     = pwdata[cfcsb_pkg::op_lsb +: cfcsb_pkg::op_w];
    wire         bad_op     = hit_cmd & (new_op >= cfcsb_pkg::op_count);

    // command, program counter and flags writes are refused while an instruction runs; operand and target writes are accepted
    wire         busy_block = pwrite & state == cfcsb_pkg::st_run & (hit_cmd | hit_pc | hit_flags);
    wire         status_ro  = pwrite & hit_stat;
    wire         refuse     = ~hit_any | (pwrite & bad_op) | busy_block | status_ro;

    // launch of an instruction
    wire         launch     = commit & pwrite & hit_cmd;

    // command fields decoded from the write data, so launch sees this command; operand fields from the registers
    wire [2:0]   bit_sel    = pwdata[cfcsb_pkg::bitsel_lsb +: 3];
    wire [2:0]   flag_sel   = pwdata[cfcsb_pkg::flagsel_lsb +: 3];
    wire         two_word   = pwdata[cfcsb_pkg::two_word_bit];
    wire [7:0]   dst_val    = operand[cfcsb_pkg::dst_lsb +: 8];
    wire [7:0]   src_val    = operand[cfcsb_pkg::src_lsb +: 8];
    wire [7:0]   imm_val    = operand[cfcsb_pkg::imm_lsb +: 8];
    wire [7:0]   io_val     = operand[cfcsb_pkg::io_lsb +: 8];
    wire [15:0]  addr_val   = target[cfcsb_pkg::addr_lsb +: 16];
    wire [6:0]   disp_val   = target[cfcsb_pkg::disp_lsb +: cfcsb_pkg::disp_w];
    wire [15:0]  disp_ext   = {{9{disp_val[6]}}, disp_val};

    // skip distance depends on the length of the skipped instruction
    wire [15:0]  skip_step  = two_word ? cfcsb_pkg::step_skip_two : cfcsb_pkg::step_skip_one;
    wire [2:0]   skip_cyc   = two_word ? cfcsb_pkg::cyc_skip_two : cfcsb_pkg::cyc_skip_one;

    // adds a step to the program counter, wrapping at 16 bits
    function automatic logic [15:0] pc_add(input logic [15:0] base, input logic [15:0] step);
        logic [15:0] sum;
        sum = base + step;
        return sum;
    endfunction

    // picks one bit of a byte
    function automatic logic bit_pick(input logic [7:0] value, input logic [2:0] sel);
        logic picked;
        picked = value[sel];
        return picked;
    endfunction

    // compare operands: immediate form swaps the subtrahend
    wire         use_imm    = (new_op == 5'(cfcsb_pkg::op_compare_immediate));
    wire         use_borrow = (new_op == 5'(cfcsb_pkg::op_compare_with_borrow));
    wire [7:0]   cmp_rhs    = use_imm ? imm_val : src_val;
    wire         cmp_bin    = use_borrow & status_flags[cfcsb_pkg::flag_c];
    logic        cmp_h;
    logic        cmp_v;
    logic        cmp_n;
    logic        cmp_z;
    logic        cmp_c;

    // subtraction flags; the difference goes nowhere
    cfcsb_compare_unit u_cmp
    (
        .minuend    (dst_val),
        .subtrahend (cmp_rhs),
        .borrow_in  (cmp_bin),
        .flag_half  (cmp_h),
        .flag_over  (cmp_v),
        .flag_neg   (cmp_n),
        .flag_zero  (cmp_z),
        .flag_carry (cmp_c)
    );

    // flags after a compare, other bits untouched
    logic [7:0]  cmp_flags;
    always_comb
    begin
        cmp_flags                       = status_flags;
        cmp_flags[cfcsb_pkg::flag_h]    = cmp_h;
        cmp_flags[cfcsb_pkg::flag_v]    = cmp_v;
        cmp_flags[cfcsb_pkg::flag_n]    = cmp_n;
        cmp_flags[cfcsb_pkg::flag_z]    = cmp_z;
        cmp_flags[cfcsb_pkg::flag_c]    = cmp_c;
    end

    // condition sources
    wire         sel_flag   = bit_pick(status_flags, flag_sel);
    wire         zero_now   = status_flags[cfcsb_pkg::flag_z];
    wire         carry_now  = status_flags[cfcsb_pkg::flag_c];
    wire         reg_bit    = bit_pick(src_val, bit_sel);
    wire         io_bit     = bit_pick(io_val, bit_sel);

    // decoded outcome of the command being launched
    logic [15:0] next_pc;
    logic [7:0]  next_flags;
    logic [2:0]  next_cycles;
    logic        next_skip;
    logic        next_taken;
    logic        do_skip;
    logic        do_branch;

    // instruction decode: outcome, flags and cycle count
    always_comb
    begin
        next_flags  = status_flags;
        next_cycles = cfcsb_pkg::cyc_single;
        do_skip     = 1'b0;
        do_branch   = 1'b0;
        next_pc     = pc_add(pc, cfcsb_pkg::step_next);
        case (cfcsb_pkg::cfcsb_op_type'(new_op))
            cfcsb_pkg::op_direct_invoke:
            begin
                next_pc     = addr_val;
                next_cycles = cfcsb_pkg::cyc_direct;
            end
            cfcsb_pkg::op_indirect_subroutine_invoke:
            begin
                next_pc     = addr_val;
                next_cycles = cfcsb_pkg::cyc_indirect;
            end
            cfcsb_pkg::op_subroutine_exit:
            begin
                next_pc     = addr_val;
                next_cycles = cfcsb_pkg::cyc_exit;
            end
            cfcsb_pkg::op_interrupt_exit:
            begin
                next_pc                       = addr_val;
                next_flags[cfcsb_pkg::flag_i] = 1'b1;
                next_cycles                   = cfcsb_pkg::cyc_exit;
            end
            cfcsb_pkg::op_compare_skip_equal:
                do_skip = (dst_val == src_val);
            cfcsb_pkg::op_compare_regs,
            cfcsb_pkg::op_compare_with_borrow,
            cfcsb_pkg::op_compare_immediate:
                next_flags = cmp_flags;
            cfcsb_pkg::op_skip_reg_bit_clear:
                do_skip = ~reg_bit;
            cfcsb_pkg::op_skip_reg_bit_set:
                do_skip = reg_bit;
            cfcsb_pkg::op_skip_io_bit_clear:
                do_skip = ~io_bit;
            cfcsb_pkg::op_skip_io_bit_set:
                do_skip = io_bit;
            cfcsb_pkg::op_branch_flag_set:
                do_branch = sel_flag;
            cfcsb_pkg::op_branch_flag_clear:
                do_branch = ~sel_flag;
            cfcsb_pkg::op_branch_equal:
                do_branch = zero_now;
            cfcsb_pkg::op_branch_not_equal:
                do_branch = ~zero_now;
            cfcsb_pkg::op_branch_carry_set:
                do_branch = carry_now;
            cfcsb_pkg::op_branch_carry_clear:
                do_branch = ~carry_now;
            default:
                next_cycles = cfcsb_pkg::cyc_single;          // refused before launch
        endcase
        // a skip jumps over one or two words
        if (do_skip)
        begin
            next_pc     = pc_add(pc, skip_step);
            next_cycles = skip_cyc;
        end
        // relative branch: displacement plus one
        if (do_branch)
        begin
            next_pc     = pc_add(pc_add(pc, disp_ext), cfcsb_pkg::step_next);
            next_cycles = cfcsb_pkg::cyc_taken;
        end
        next_skip  = do_skip;
        next_taken = do_branch;
    end

    // cycle timer for the running instruction
    logic        tmr_busy;
    logic        tmr_last;
    cfcsb_cycle_timer #(.W(3)) u_tmr
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .load    (launch),
        .count   (next_cycles),
        .busy    (tmr_busy),
        .last    (tmr_last)
    );

    // results land on the final cycle of the instruction
    wire         finish     = (state == cfcsb_pkg::st_run) & tmr_last;

    // read data mux
    wire [31:0]  status_word = {24'h00_0000, 1'b0, last_cycles, 1'b0, taken, skipped, tmr_busy};
    wire [31:0]  rd_data =
        hit_cmd   ? cmd :
        hit_oper  ? operand :
        hit_tgt   ? target :
        hit_pc    ? {16'h0000, pc} :
        hit_flags ? {24'h00_0000, status_flags} :
        hit_stat  ? status_word : cfcsb_pkg::word_reset;

    // apb answer: one wait state, error flagged with ready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= cfcsb_pkg::word_reset;
        end
        else if (ce)
        begin
            pready  <= setup_done;
            pslverr <= setup_done & refuse;
            // read data sampled once, so it cannot shift during the access
            if (setup_done)
                prdata <= (pwrite | refuse) ? cfcsb_pkg::word_reset : rd_data;
        end
    end

    // operand and target registers, freely writable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            operand <= cfcsb_pkg::word_reset;
            target  <= cfcsb_pkg::word_reset;
        end
        else if (ce & commit & pwrite)
        begin
            if (hit_oper)
                operand <= pwdata;
            if (hit_tgt)
                target <= pwdata;
        end
    end

    // sequencer: launch captures the outcome, finish commits it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state       <= cfcsb_pkg::st_idle;
            cmd         <= cfcsb_pkg::word_reset;
            pend_pc     <= cfcsb_pkg::pc_reset;
            pend_flags  <= cfcsb_pkg::flags_reset;
            skipped     <= 1'b0;
            taken       <= 1'b0;
            last_cycles <= 3'h0;
            exec_busy   <= 1'b0;
        end
        else if (ce)
        begin
            case (state)
                cfcsb_pkg::st_idle:
                begin
                    if (launch)
                    begin
                        state       <= cfcsb_pkg::st_run;
                        cmd         <= pwdata;
                        pend_pc     <= next_pc;
                        pend_flags  <= next_flags;
                        skipped     <= next_skip;
                        taken       <= next_taken;
                        last_cycles <= next_cycles;
                        exec_busy   <= 1'b1;
                    end
                end
                cfcsb_pkg::st_run:
                begin
                    // the timer bounds the run to the instruction's cycles
                    if (finish)
                    begin
                        state     <= cfcsb_pkg::st_idle;
                        exec_busy <= 1'b0;
                    end
                end
                default:
                    state <= cfcsb_pkg::st_idle;
            endcase
        end
    end

    // program counter and flags: commit at finish, else software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc           <= cfcsb_pkg::pc_reset;
            status_flags <= cfcsb_pkg::flags_reset;
        end
        else if (ce)
        begin
            if (finish)
            begin
                pc           <= pend_pc;
                status_flags <= pend_flags;
            end
            else if (commit & pwrite & hit_pc)
                pc <= pwdata[15:0];
            else if (commit & pwrite & hit_flags)
                status_flags <= pwdata[7:0];
        end
    end
endmodule
`default_nettype wire

// *** tb/cfcsb_flow_unit_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module cfcsb_flow_unit_monitor
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // execution
    input wire logic        exec_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // accepted command write, launches an instruction
    wire logic              cmd_wr = pready && pwrite && !pslverr && paddr == cfcsb_pkg::cmd_off;
    wire logic              cmd_hit = pready && pwrite && paddr == cfcsb_pkg::cmd_off;

    a_one_wait: assert property (ce && psel && penable && !pready |=> pready)
        else $error("answer not after one wait state");
    a_ready_pulse: assert property (ce && pready |=> !pready)
        else $error("ready longer than one cycle");
    a_idle_quiet: assert property (ce && !psel |=> !pready)
        else $error("answer without select");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("write answered with data");
    a_launch_busy: assert property (cmd_wr |=> exec_busy)
        else $error("command did not start");
    a_busy_max: assert property ($rose(exec_busy) |-> ##[1:4] !exec_busy)
        else $error("run longer than four cycles");
    a_busy_refuse: assert property (exec_busy && cmd_hit |-> pslverr)
        else $error("command taken while running");
    a_bad_place: assert property (pready && (paddr > cfcsb_pkg::status_off ||
                                  pwrite && paddr == cfcsb_pkg::status_off) |-> pslverr)
        else $error("bad address not refused");

    // main scenarios
    c_launch: cover property (cmd_wr);
    c_refused: cover property (pslverr);
    c_done: cover property ($fell(exec_busy));
endmodule

bind cfcsb_flow_unit cfcsb_flow_unit_monitor u_cfcsb_flow_unit_monitor
(.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_busy);
`default_nettype wire

// *** tb/cpu_flow_control_compare_skip_branch_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module cpu_flow_control_compare_skip_branch_test;
    logic        pclk    = 1'h0;
    logic        presetn = 1'h0;
    logic        ce      = 1'h1;    // held high, freezing is not exercised
    logic        psel    = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite  = 1'h0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        exec_busy;
    int          n_errors = 0;
    int          n_tests  = 0;
    logic [32:0] notes [$];          // expected {error, data} per access
    logic [31:0] opd, tgt, cmd, e;
    logic [15:0] pc;
    logic [7:0]  fl;
    int          n;

    cfcsb_flow_unit u_cfcsb_flow_unit
    (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_busy);

    initial forever #2 pclk = ~pclk;

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic finish_test;
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // each answered access retires the oldest note
    always @(posedge pclk)
        if (psel && penable && pready)
            check({pslverr, prdata}, notes.size() ? notes.pop_front() : 33'hX);

    // one apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
        int k;
        notes.push_back(x);
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (!pready && k < 16);
        if (!pready)
        begin
            n_errors++;
            finish_test();
        end
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'h1, a, d, {err, 32'h0});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'h0, a, 32'h0, {1'h0, d});
    endtask

    // expected {status, flags, pc} after one instruction
    function automatic logic [31:0] model(input logic [31:0] c, o, t, input logic [15:0] p, input logic [7:0] f);
        logic [4:0] op;
        logic [7:0] b;
        logic [8:0] r;
        logic [4:0] h;
        logic       s, k, cin;
        logic [2:0] y;
        op  = c[4:0];
        b   = op == 5'h7 ? o[23:16] : o[15:8];
        cin = op == 5'h6 && f[0];
        r   = {1'h0, o[7:0]} - b - cin;
        h   = {1'h0, o[3:0]} - b[3:0] - cin;
        s   = op == 5'h4 ? o[7:0] == o[15:8] : op == 5'h8 ? !o[8 + c[10:8]] : op == 5'h9 ? o[8 + c[10:8]] :
              op == 5'hA ? !o[24 + c[10:8]] : op == 5'hB && o[24 + c[10:8]];
        k   = op >= 5'hC && (op < 5'hE ? f[c[14:12]] : op < 5'h10 ? f[1] : f[0]) == !op[0];
        y   = op < 5'h4 ? (op == 5'h1 ? 3'h3 : 3'h4) : s ? 3'h2 + c[16] : k ? 3'h2 : 3'h1;
        if (op == 5'h3)
            f[7] = 1'h1;
        if (op >= 5'h5 && op <= 5'h7)
            f = {f[7:6], h[4], f[4], o[7] != b[7] && r[7] != o[7], r[7], r[7:0] == 8'h0, r[8]};
        p   = op < 5'h4 ? t[15:0] : s ? p + 16'h2 + c[16] : k ? p + {{9{t[22]}}, t[22:16]} + 16'h1 : p + 16'h1;
        return {1'h0, y, 1'h0, k, s, 1'h0, f, p};
    endfunction

    initial
    begin
        void'($urandom(32'hCAEB48EF));
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 0; a < 24; a += 4)
            rd(a[7:0], 32'h0);
        apb(1'h0, 8'h18, 32'h0, {1'h1, 32'h0});
        wr(cfcsb_pkg::status_off, 32'h1, 1'h1);
        wr(cfcsb_pkg::cmd_off, 32'h12, 1'h1);
        // every instruction four times with random operands
        for (int i = 0; i < 72; i++)
        begin
            opd = $urandom;
            if ($urandom & 1)
                opd[15:8] = opd[7:0];
            tgt = $urandom & 32'h007F_FFFF;
            pc  = $urandom;
            fl  = $urandom;
            cmd = ($urandom & 32'h0001_7700) | (i % 18);
            e   = model(cmd, opd, tgt, pc, fl);
            wr(cfcsb_pkg::operand_off, opd, 1'h0);
            wr(cfcsb_pkg::target_off, tgt, 1'h0);
            wr(cfcsb_pkg::pc_off, {16'h0, pc}, 1'h0);
            wr(cfcsb_pkg::flags_off, {24'h0, fl}, 1'h0);
            wr(cfcsb_pkg::cmd_off, cmd, 1'h0);
            if (i % 18 == 0)
                wr(cfcsb_pkg::cmd_off, cmd, 1'h1);
            @(posedge pclk);
            for (n = 0; exec_busy && n < 16; n++)
                @(posedge pclk);
            check(n < 16, 1'h1);
            rd(cfcsb_pkg::pc_off, {16'h0, e[15:0]});
            rd(cfcsb_pkg::flags_off, {24'h0, e[23:16]});
            rd(cfcsb_pkg::status_off, {24'h0, e[31:24]});
        end
        finish_test();
    end
endmodule
`default_nettype wire
